/* rts_far_side.sv */
`timescale 1ns/10ps
module rts_far_side (
  input  wire logic supply_up,
  input  wire logic power_n,
  output logic      osc_in,
  output logic      vdd_ok,
  output logic      por_pulse
);
  logic up_seen;
  initial begin
    osc_in = 1'b0;
    up_seen = 1'b0;
  end
  // crystal runs free, slow enough that every rise is seen by the system clock
  always #20 osc_in = ~osc_in;
  // power-on pulse only on a cold start; a falling supply never raises it again
  always @(supply_up or power_n) begin
    if (!power_n) up_seen = 1'b0;
    else if (supply_up) up_seen = 1'b1;
  end
  assign por_pulse = !up_seen;
  assign vdd_ok    = supply_up;
endmodule

/* rts_pkg.sv */
package rts_pkg;

  // register offsets (word indices, byte address is index times 4; printed offsets kept as indices)
  localparam logic [7:0] RTS_IDX_STATUS = 8'h03;
  localparam logic [7:0] RTS_IDX_POWER_CTRL_REG   = 8'h8e;
  localparam logic [7:0] RTS_IDX_CFG    = 8'h40;
  localparam logic [7:0] RTS_IDX_STATE  = 8'h41;
  localparam logic [7:0] RTS_IDX_PC     = 8'h42;
  localparam logic [7:0] RTS_IDX_PIR    = 8'h43;
  localparam logic [7:0] RTS_IDX_OPT    = 8'h44;

  // status register bits
  localparam int RTS_ST_TO = 4;
  localparam int RTS_ST_PD = 3;
  // power control bits
  localparam int RTS_PC_OSC_SPEED_SEL = 3;
  localparam int RTS_PC_POR  = 1;
  localparam int RTS_PC_BOD  = 0;
  // configuration register bits, and the pir compare flag bit
  localparam int RTS_CF_PWRTOFF = 0;
  localparam int RTS_CF_BROWNOUT_ENABLE   = 1;
  localparam int RTS_CF_MODE_LO = 2;
  localparam int RTS_PIR_CMP    = 6;

  localparam logic [7:0] RTS_STATUS_POR  = 8'h18;
  localparam logic [7:0] RTS_POWER_CTRL_REG_POR    = 8'h08;
  localparam logic [7:0] RTS_POWER_CTRL_REG_MASK   = 8'h0b;
  localparam logic [7:0] RTS_OPTION_RST  = 8'hff;
  localparam logic [7:0] RTS_CFG_RST     = 8'h04;
  localparam logic [12:0] RTS_PC_RESET   = 13'h0000;
  localparam logic [12:0] RTS_PC_VECTOR  = 13'h0004;

  // timing: 72 ms power-up timer, counted on rc clock enable pulses
  localparam int RTS_POWER_UP_TIMER_MS      = 72;
  localparam int RTS_RC_KHZ       = 37;
  localparam int RTS_POWER_UP_TIMER_TICKS   = RTS_POWER_UP_TIMER_MS * RTS_RC_KHZ;
  localparam int RTS_CLK_MHZ      = 125;
  localparam int RTS_RC_DIV       = (RTS_CLK_MHZ * 1000) / RTS_RC_KHZ;
  localparam logic [10:0] RTS_OST_CYCLES = 11'd1024;
  localparam logic [3:0]  RTS_MASTER_CLEAR_N_FILT  = 4'h8;

  typedef enum logic [2:0] {
    RTS_M_LP  = 3'b000,
    RTS_M_XT  = 3'b001,
    RTS_M_HS  = 3'b010,
    RTS_M_EC  = 3'b011,
    RTS_M_RC  = 3'b100,
    RTS_M_ER  = 3'b110
  } rts_mode_t;

  typedef enum logic [2:0] {
    RTS_S_HOLD = 3'b000,
    RTS_S_POWER_UP_TIMER = 3'b001,
    RTS_S_OST  = 3'b010,
    RTS_S_RUN  = 3'b011,
    RTS_S_SLP  = 3'b100
  } rts_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rts_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rts_apb_rsp_t;

  typedef struct packed {
    logic por_pulse;
    logic vdd_ok;
    logic wdt_timeout;
    logic sleep_req;
    logic irq_wake;
    logic cmp_wake;
    logic global_irq_en;
  } rts_evt_t;

endpackage

/* rts_sequencer.sv */
// Local design decision: the APB slave port.
`timescale 1ns/10ps
module rts_sequencer
  import rts_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               resetn,
  input  wire rts_pkg::rts_apb_req_t apb_req,
  output rts_pkg::rts_apb_rsp_t   apb_rsp,
  input  wire rts_pkg::rts_evt_t  evt,
  input  wire logic               master_clear_n,
  input  wire logic               osc_in,
  output logic                    core_reset_n,
  output logic                    core_sleeping,
  output logic [12:0]             core_pc,
  output logic                    pc_load,
  output logic                    osc_speed_sel
);
  import rts_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // configuration and software registers
  // cfg_q stands in for the configuration fuses: bit 0 turns the power-up
  // timer off, bit 1 arms brown-out detection, bits 4:2 pick the oscillator.
  // it is reset by resetn only, so a brown-out or watchdog reset keeps the
  // mode that software chose, but the sequence after it skips the oscillator start-up count once the core has run.

  logic [7:0] cfg_q;
  logic [7:0] status_q;
  logic [7:0] power_ctrl_reg_q;
  logic [7:0] pir_q;
  logic [7:0] option_q;
  rts_state_t state_q;
  rts_state_t state_d;

  wire        power_up_timer_off  = cfg_q[RTS_CF_PWRTOFF];
  wire        bod_en    = cfg_q[RTS_CF_BROWNOUT_ENABLE];
  wire [2:0]  mode      = cfg_q[RTS_CF_MODE_LO +: 3];
  wire        xtal_mode = (mode == RTS_M_LP) || (mode == RTS_M_XT) || (mode == RTS_M_HS);

  // the register bus has no wait states; a write lands at the edge that
  // samples the access phase, and unmapped words are refused with pslverr.
  wire        apb_wr   = apb_req.psel && apb_req.penable && apb_req.pwrite;
  wire [9:0]  word_idx = apb_req.paddr[11:2];
  wire        sel_st   = (word_idx == {2'b00, RTS_IDX_STATUS});
  wire        sel_pc   = (word_idx == {2'b00, RTS_IDX_POWER_CTRL_REG});
  wire        sel_cf   = (word_idx == {2'b00, RTS_IDX_CFG});
  wire        sel_sm   = (word_idx == {2'b00, RTS_IDX_STATE});
  wire        sel_pcv  = (word_idx == {2'b00, RTS_IDX_PC});
  wire        sel_pir  = (word_idx == {2'b00, RTS_IDX_PIR});
  wire        sel_opt  = (word_idx == {2'b00, RTS_IDX_OPT});
  wire        sel_any  = sel_st | sel_pc | sel_cf | sel_sm | sel_pcv | sel_pir | sel_opt;

  //////////////////////////////////////////////////////////////////////////////
  // reset cause detection

  logic [3:0] master_clear_n_cnt_q;
  logic       master_clear_n_low_q;

  // brown-out only acts when detection is enabled; falling supply alone never
  // raises the power-on path
  wire bod_evt = bod_en && !evt.vdd_ok;
  wire por_evt = evt.por_pulse;

  // low must persist for the filter length before it counts
  always_ff @(posedge clock) begin
    if (!resetn || master_clear_n) begin
      master_clear_n_cnt_q <= 4'h0;
    end else if (master_clear_n_cnt_q != RTS_MASTER_CLEAR_N_FILT) begin
      master_clear_n_cnt_q <= master_clear_n_cnt_q + 4'h1;
    end
  end
  wire master_clear_n_evt = (master_clear_n_cnt_q == RTS_MASTER_CLEAR_N_FILT);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      master_clear_n_low_q <= 1'b0;
    end else begin
      master_clear_n_low_q <= master_clear_n_evt;
    end
  end
  wire master_clear_n_start = master_clear_n_evt && !master_clear_n_low_q;
  // master_clear_n_start is a one-cycle strobe at the filtered fall of the pin; it
  // applies the register reset once, while the release stays held off by
  // master_clear_n_evt for as long as the pin is low.

  //////////////////////////////////////////////////////////////////////////////
  // rc clock enable and timers

  logic [15:0] rc_div_q;
  logic [17:0] power_up_timer_cnt_q;
  logic [10:0] ost_cnt_q;
  logic [1:0]  osc_hist_q;

  // the slow rc clock is a one-cycle enable from a divider of the system
  // clock; the 72 ms count is therefore exact in system cycles, where the
  // real rc oscillator would drift with supply and temperature.
  wire rc_tick = (rc_div_q == 16'(RTS_RC_DIV - 1));
  always_ff @(posedge clock) begin
    if (!resetn || rc_tick) begin
      rc_div_q <= 16'h0000;
    end else begin
      rc_div_q <= rc_div_q + 16'h0001;
    end
  end

  // osc_in is taken as synchronous; count its rising edges
  always_ff @(posedge clock) begin
    if (!resetn) begin
      osc_hist_q <= 2'b00;
    end else begin
      osc_hist_q <= {osc_hist_q[0], osc_in};
    end
  end
  wire osc_rise = osc_hist_q[0] && !osc_hist_q[1];
  // osc_in must stay below half the system clock rate, or rises are lost
  // and the start-up count stretches.

  wire power_up_timer_done = (power_up_timer_cnt_q == 18'(RTS_POWER_UP_TIMER_TICKS));
  wire ost_done  = (ost_cnt_q == RTS_OST_CYCLES);

  // a supply dip clears the power-up count at once, so the full delay runs
  // again after the supply has recovered.

  always_ff @(posedge clock) begin
    if (!resetn || state_q != RTS_S_POWER_UP_TIMER || !evt.vdd_ok) begin
      power_up_timer_cnt_q <= 18'h00000;
    end else if (rc_tick && !power_up_timer_done) begin
      power_up_timer_cnt_q <= power_up_timer_cnt_q + 18'h00001;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || state_q != RTS_S_OST) begin
      ost_cnt_q <= 11'h000;
    end else if (osc_rise && !ost_done) begin
      ost_cnt_q <= ost_cnt_q + 11'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequence state machine

  logic pwr_cycle_q;   // current sequence came from power-on
  logic wake_q;        // start-up timer run belongs to a wake-up

  // watchdog and interrupt only wake the core while it sleeps; a watchdog
  // timeout in normal running is a full reset instead.

  wire wdt_wake  = (state_q == RTS_S_SLP) && evt.wdt_timeout;
  wire irq_wake  = (state_q == RTS_S_SLP) && evt.irq_wake;
  wire any_wake  = wdt_wake || irq_wake;
  wire wdt_reset = (state_q == RTS_S_RUN) && evt.wdt_timeout;
  wire ost_after_power_up_timer = xtal_mode && pwr_cycle_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      RTS_S_HOLD: begin
        // wait for the supply, then pick the first timer
        if (evt.vdd_ok) begin
          if (!power_up_timer_off) begin
            state_d = RTS_S_POWER_UP_TIMER;
          end else if (ost_after_power_up_timer) begin
            state_d = RTS_S_OST;
          end else begin
            state_d = RTS_S_RUN;
          end
        end
      end
      RTS_S_POWER_UP_TIMER: begin
        if (power_up_timer_done) begin
          state_d = ost_after_power_up_timer ? RTS_S_OST : RTS_S_RUN;
        end
      end
      RTS_S_OST: begin
        if (ost_done) begin
          state_d = RTS_S_RUN;
        end
      end
      RTS_S_RUN: begin
        if (wdt_reset) begin
          state_d = RTS_S_HOLD;
        end else if (evt.sleep_req) begin
          state_d = RTS_S_SLP;
        end
      end
      RTS_S_SLP: begin
        if (any_wake) begin
          state_d = xtal_mode ? RTS_S_OST : RTS_S_RUN;
        end
      end
      default: state_d = RTS_S_HOLD;
    endcase
    // power-on and brown-out always restart from the supply wait
    if (por_evt || bod_evt) begin
      state_d = RTS_S_HOLD;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q     <= RTS_S_HOLD;
      pwr_cycle_q <= 1'b1;
      wake_q      <= 1'b0;
    end else begin
      state_q     <= state_d;
      if (por_evt) begin
        pwr_cycle_q <= 1'b1;
      end else if (state_q == RTS_S_RUN) begin
        pwr_cycle_q <= 1'b0;
      end
      wake_q      <= any_wake ? 1'b1 : (state_q == RTS_S_RUN ? 1'b0 : wake_q);
    end
  end

  // timers ignore the pin; the pin only gates final release
  // registered so release lines up with a system clock edge
  always_ff @(posedge clock) begin
    if (!resetn) begin
      core_reset_n <= 1'b0;
    end else begin
      core_reset_n <= (state_d == RTS_S_RUN || state_d == RTS_S_SLP) && !master_clear_n_evt;
    end
  end
  assign core_sleeping = (state_q == RTS_S_SLP);
  // core_sleeping follows the state register, so it drops at the same edge
  // as the wake-up is taken and the start-up count begins.

  //////////////////////////////////////////////////////////////////////////////
  // register updates on reset events
  // priority: power-on first, then the other full resets, then wake-ups,
  // and only then software writes, so a reset event in the same cycle as a
  // write to any register but cfg_q always wins.

  wire full_reset = por_evt || bod_evt || wdt_reset || master_clear_n_start;
  wire st_wr   = apb_wr && sel_st;
  wire power_ctrl_reg_wr = apb_wr && sel_pc;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      status_q <= RTS_STATUS_POR;
      power_ctrl_reg_q   <= RTS_POWER_CTRL_REG_POR;
      option_q <= RTS_OPTION_RST;
      pir_q    <= 8'h00;
      cfg_q    <= RTS_CFG_RST;
    end else begin
      if (apb_wr && sel_cf) begin
        cfg_q <= apb_req.pwdata[7:0];
      end
      if (apb_wr && sel_opt) begin
        option_q <= apb_req.pwdata[7:0];
      end
      if (por_evt) begin
        status_q <= RTS_STATUS_POR;
        power_ctrl_reg_q   <= RTS_POWER_CTRL_REG_POR;
        option_q <= RTS_OPTION_RST;
        pir_q    <= 8'h00;
      end else if (full_reset) begin
        status_q[7:5] <= 3'b000;
        if (wdt_reset) begin
          status_q[RTS_ST_TO] <= 1'b0;
        end else if (master_clear_n_start && state_q == RTS_S_SLP) begin
          status_q[RTS_ST_TO] <= 1'b1;
          status_q[RTS_ST_PD] <= 1'b0;
        end
        // brown-out flag only meaningful while detection enabled
        power_ctrl_reg_q[RTS_PC_BOD]  <= bod_evt ? 1'b0 : power_ctrl_reg_q[RTS_PC_BOD];
        power_ctrl_reg_q[RTS_PC_OSC_SPEED_SEL] <= 1'b1;
        option_q <= RTS_OPTION_RST;
        pir_q    <= 8'h00;
      end else if (any_wake) begin
        status_q[RTS_ST_TO] <= !wdt_wake;
        status_q[RTS_ST_PD] <= 1'b0;
        if (evt.cmp_wake) begin
          pir_q[RTS_PIR_CMP] <= 1'b1;
        end
      end else begin
        if (st_wr) begin
          status_q <= {apb_req.pwdata[7:5], status_q[4:3], apb_req.pwdata[2:0]};
        end
        if (power_ctrl_reg_wr) begin
          power_ctrl_reg_q <= apb_req.pwdata[7:0] & RTS_POWER_CTRL_REG_MASK;
        end
        if (apb_wr && sel_pir) begin
          pir_q <= apb_req.pwdata[7:0];
        end
        if (evt.sleep_req && state_q == RTS_S_RUN) begin
          status_q[RTS_ST_PD] <= 1'b0;
          status_q[RTS_ST_TO] <= 1'b1;
        end
      end
    end
  end

  // in crystal modes the speed bit still reads back but has no effect
  assign osc_speed_sel = power_ctrl_reg_q[RTS_PC_OSC_SPEED_SEL] && !xtal_mode;

  //////////////////////////////////////////////////////////////////////////////
  // program counter load
  // the block only forces the pc on a full reset or, in crystal modes, an interrupt vector;
  // on a plain wake-up the core goes on at its own pc+1 and pc_load stays low.

  logic [12:0] pc_q;
  logic        pc_load_q;
  logic        vec_pend_q;
  wire         wake_release = wake_q && (state_d == RTS_S_RUN) && (state_q != RTS_S_RUN);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pc_q       <= RTS_PC_RESET;
      pc_load_q  <= 1'b0;
      vec_pend_q <= 1'b0;
    end else if (full_reset) begin
      pc_q       <= RTS_PC_RESET;
      pc_load_q  <= 1'b1;
      vec_pend_q <= 1'b0;
    end else if (irq_wake) begin
      vec_pend_q <= evt.global_irq_en;
      pc_load_q  <= 1'b0;
    end else if (wake_release && vec_pend_q) begin
      // pc+1 is the core's own next fetch; vector follows it
      pc_q       <= RTS_PC_VECTOR;
      pc_load_q  <= 1'b1;
      vec_pend_q <= 1'b0;
    end else begin
      pc_load_q  <= 1'b0;
    end
  end
  assign core_pc = pc_q;
  assign pc_load = pc_load_q;

  //////////////////////////////////////////////////////////////////////////////
  // apb read side; single-cycle access, unmapped reads zero with pslverr

  wire [7:0] rd_byte = sel_st  ? status_q :
                       sel_pc  ? power_ctrl_reg_q :
                       sel_cf  ? cfg_q :
                       sel_sm  ? {5'h00, state_q} :
                       sel_pir ? pir_q :
                       sel_opt ? option_q : 8'h00;
  wire [31:0] rd_word = sel_pcv ? {19'h00000, pc_q} : {24'h000000, rd_byte};

  // prdata is zero outside a read so the bus never shows stale contents
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !sel_any;
  assign apb_rsp.prdata  = (apb_req.psel && !apb_req.pwrite) ? rd_word : 32'h00000000;


endmodule

/* rts_sequencer_assertions.sv */
`timescale 1ns/10ps
module rts_chk
  import rts_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  resetn,
  input wire rts_pkg::rts_apb_req_t apb_req,
  input wire rts_pkg::rts_evt_t     evt,
  input wire logic                  master_clear_n,
  input wire logic                  core_reset_n,
  input wire logic                  core_sleeping,
  input wire logic                  pc_load,
  input wire logic [12:0]           core_pc,
  input wire logic                  osc_speed_sel
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////
  // shadow of the configuration word, so rules that hinge on mode can be judged
  logic [4:0] cfg_q;
  wire        wr_cfg = apb_req.psel && apb_req.penable && apb_req.pwrite
                       && apb_req.paddr == {2'b00, RTS_IDX_CFG, 2'b00};
  wire        xtal   = cfg_q[4:3] == 2'b00 || cfg_q[4:2] == 3'b010;
  always_ff @(posedge clock) begin
    if (!resetn) cfg_q <= RTS_CFG_RST[4:0];
    else if (wr_cfg) cfg_q <= apb_req.pwdata[4:0];
  end
  ////////////////////////////////////////////////////////////////
  a_hold_no_supply: assert property (!core_reset_n && !evt.vdd_ok |=> !core_reset_n)
    else $error("reset released while supply low");
  a_release_pin: assert property ($rose(core_reset_n) |-> $past(master_clear_n))
    else $error("reset released while pin low");
  a_pin_glitch: assert property (core_reset_n && $fell(master_clear_n) ##1 master_clear_n
    |=> core_reset_n [*4])
    else $error("short pin pulse caused a reset");
  a_wdt_reset: assert property (core_reset_n && !core_sleeping && evt.wdt_timeout
    |-> ##[1:4] !core_reset_n)
    else $error("watchdog timeout did not reset");
  a_wdt_pc_load: assert property (core_reset_n && !core_sleeping && evt.wdt_timeout
    |=> pc_load && core_pc == RTS_PC_RESET)
    else $error("watchdog reset did not load the reset pc");
  a_sleep_entry: assert property (core_reset_n && !core_sleeping && evt.sleep_req
    |-> ##[1:3] core_sleeping)
    else $error("sleep not entered");
  a_bod_reset: assert property (cfg_q[1] && core_reset_n && !evt.vdd_ok
    |-> ##[1:16] !core_reset_n)
    else $error("brown-out did not reset");
  a_bod_off: assert property (!cfg_q[1] && core_reset_n && !evt.vdd_ok |=> core_reset_n)
    else $error("supply dip reset with detection off");
  a_speed_xtal: assert property (xtal |-> !osc_speed_sel)
    else $error("speed select active in crystal mode");
  a_ost_hold: assert property (xtal && $fell(evt.por_pulse) |-> ##300 !core_reset_n)
    else $error("start-up count cut short");
endmodule

bind rts_sequencer rts_chk i_chk (.clock(clock), .resetn(resetn), .apb_req(apb_req),
  .evt(evt), .master_clear_n(master_clear_n), .core_reset_n(core_reset_n),
  .core_sleeping(core_sleeping), .pc_load(pc_load), .core_pc(core_pc),
  .osc_speed_sel(osc_speed_sel));

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
  import rts_pkg::*;
  logic         clock = 1'b0;
  logic         resetn = 1'b0;
  rts_apb_req_t apb_req = '0;
  rts_apb_rsp_t apb_rsp;
  rts_evt_t     evt;
  logic         master_clear_n = 1'b0;
  logic         supply_up = 1'b0;
  logic [2:0]   ev_p = 3'b000;
  logic         cmp = 1'b0;
  logic         osc_in, vdd_ok, por_pulse, core_reset_n, core_sleeping, pc_load, osc_speed_sel;
  logic [12:0]  core_pc;
  logic [7:0]   opt;
  logic [31:0]  rdat;
  logic         err;
  int           miscompares = 0;
  int           checks = 0;

  always #4 clock = ~clock;
  assign evt = '{por_pulse: por_pulse, vdd_ok: vdd_ok, wdt_timeout: ev_p[2],
                 sleep_req: ev_p[1], irq_wake: ev_p[0], cmp_wake: cmp, global_irq_en: 1'b0};
  rts_far_side i_far (.supply_up(supply_up), .power_n(resetn), .osc_in(osc_in),
    .vdd_ok(vdd_ok), .por_pulse(por_pulse));
  rts_sequencer i_dut (.clock(clock), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .evt(evt), .master_clear_n(master_clear_n), .osc_in(osc_in), .core_reset_n(core_reset_n),
    .core_sleeping(core_sleeping), .core_pc(core_pc), .pc_load(pc_load),
    .osc_speed_sel(osc_speed_sel));
  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] st_exp(input logic to_n, input logic pd_n);
    return {3'b000, to_n, pd_n, 3'b000};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clock);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {2'b00, idx, 2'b00}, pwdata: d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] x);
    apb(1'b0, idx, 32'h0, rdat, err);
    chk({24'h0, rdat[7:0] & m}, {24'h0, x});
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, rdat, err);
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge clock);
    ev_p <= m;
    @(posedge clock);
    ev_p <= 3'b000;
  endtask
  // bounded wait on a level; a wait that runs out shows up as a failed compare
  task automatic wait_for(ref logic s, input logic lvl, input int lim);
    int n;
    n = 0;
    while (s !== lvl && n < lim) begin
      @(posedge clock);
      n++;
    end
    chk(32'(s), 32'(lvl));
  endtask
  task automatic power_up(input logic [31:0] cfg, input logic pin);
    resetn <= 1'b0;
    supply_up <= 1'b0;
    master_clear_n <= pin;
    cyc(10);
    resetn <= 1'b1;
    rd(RTS_IDX_STATUS, 8'hff, RTS_STATUS_POR);
    rd(RTS_IDX_POWER_CTRL_REG, 8'hff, RTS_POWER_CTRL_REG_POR);
    rd(RTS_IDX_OPT, 8'hff, RTS_OPTION_RST);
    wr(RTS_IDX_CFG, cfg);
    supply_up <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h80b142b0));
    power_up(32'h05, 1'b0);
    apb(1'b1, 8'h50, 32'h0, rdat, err);
    chk(32'(err), 32'h1);
    cyc(5400);
    chk(32'(core_reset_n), 32'h0);
    master_clear_n <= 1'b1;
    wait_for(core_reset_n, 1'b1, 16);
    chk({19'h0, core_pc}, 32'h0);
    chk(32'(osc_speed_sel), 32'h0);
    for (int w = 1; w < 7; w += 5) begin
      master_clear_n <= 1'b0;
      cyc(w);
      master_clear_n <= 1'b1;
      cyc(20);
      chk(32'(core_reset_n), 32'h1);
    end
    wr(RTS_IDX_POWER_CTRL_REG, 32'h0b);
    opt = 8'($urandom);
    wr(RTS_IDX_OPT, {24'h0, opt});
    pulse(3'b100);
    wait_for(core_reset_n, 1'b0, 8);
    wait_for(core_reset_n, 1'b1, 64);
    rd(RTS_IDX_STATUS, 8'h18, st_exp(1'b0, 1'b1));
    rd(RTS_IDX_OPT, 8'hff, RTS_OPTION_RST);
    rd(RTS_IDX_POWER_CTRL_REG, 8'h03, 8'h03);
    master_clear_n <= 1'b0;
    cyc(20);
    chk(32'(core_reset_n), 32'h0);
    master_clear_n <= 1'b1;
    wait_for(core_reset_n, 1'b1, 64);
    rd(RTS_IDX_STATUS, 8'h18, st_exp(1'b0, 1'b1));
    supply_up <= 1'b0;
    cyc(5);
    supply_up <= 1'b1;
    cyc(3);
    chk(32'(core_reset_n), 32'h1);
    opt = 8'($urandom);
    wr(RTS_IDX_OPT, {24'h0, opt});
    pulse(3'b010);
    wait_for(core_sleeping, 1'b1, 8);
    pulse(3'b100);
    cyc(4900);
    rd(RTS_IDX_STATE, 8'h07, {5'h0, RTS_S_OST});
    cyc(400);
    rd(RTS_IDX_STATE, 8'h07, {5'h0, RTS_S_RUN});
    chk({19'h0, core_pc}, 32'h0);
    rd(RTS_IDX_STATUS, 8'h18, st_exp(1'b0, 1'b0));
    rd(RTS_IDX_OPT, 8'hff, opt);
    pulse(3'b010);
    wait_for(core_sleeping, 1'b1, 8);
    cmp <= 1'b1;
    pulse(3'b001);
    cmp <= 1'b0;
    cyc(5400);
    rd(RTS_IDX_PIR, 8'h40, 8'h40);
    rd(RTS_IDX_STATUS, 8'h18, st_exp(1'b1, 1'b0));
    // timer kept on with detection on; the long count is only watched, never waited out
    wr(RTS_IDX_CFG, 32'h06);
    supply_up <= 1'b0;
    wait_for(core_reset_n, 1'b0, 16);
    rd(RTS_IDX_POWER_CTRL_REG, 8'h03, 8'h02);
    supply_up <= 1'b1;
    cyc(2000);
    rd(RTS_IDX_STATE, 8'h07, {5'h0, RTS_S_POWER_UP_TIMER});
    chk(32'(core_reset_n), 32'h0);
    supply_up <= 1'b0;
    cyc(4);
    rd(RTS_IDX_STATE, 8'h07, {5'h0, RTS_S_HOLD});
    power_up(32'h19, 1'b1);
    wait_for(core_reset_n, 1'b1, 40);
    chk(32'(osc_speed_sel), 32'h1);
    finish_test();
  end
  initial begin
    cyc(40000);
    miscompares++;
    finish_test();
  end
endmodule
